// ---- src/dsp_external_memory_interface.sv ----
// Notes on behaviour
// RL1 - One 14-bit external address bus spans 16K words, 1K of them on chip.
// RL2 - Program and data accesses share one address bus and one data bus.
// RL3 - The data bus is 24 bits two-way; program memory holds code and data.
// RL4 - Program select goes low for every external program access.
// RL5 - Data select goes low for every external data access.
// RL6 - Shared low write strobe for writes, shared low read strobe for reads.
// RL7 - Program writes from 16-bit data take the low byte from the extension.
// RL8 - Program data reads leave the low byte in the extension register.
// RL9 - Strap low: internal program RAM at 0, reserved 0x0400-0x07FF, rest out.
// RL10 - Strap high: external from 0, internal at 0x3800, 0x3C00 up reserved.
// RL11 - Strap high: no boot load, program access to internal RAM still works.
// RL12 - Program accesses get 0 to 7 wait states, seven after reset.
// RL13 - Data accesses use 14 address bits and the upper 16 data lanes.
// RL14 - Mapped peripherals see exactly the data memory bus cycle.
// RL15 - 512 data RAM words at 0x3800; 0x3A00 up is held internal.
// RL16 - Control registers sit in the internal region, never on the pins.
// RL17 - External data space has five zones, each with its own wait count.
// RL18 - Every data zone starts with seven wait states after reset.
// RL19 - Each wait state stretches select and strobe by one cycle.
// RL20 - Zone bounds and wait settings come from parameters and inputs.
`default_nettype none
module dsp_external_memory_interface #(
  parameter logic [(ext_mem_pkg::NUM_ZONES-1)*ext_mem_pkg::ADDR_W-1:0]
    ZONE_BOUNDS = ext_mem_pkg::ZONE_BOUNDS
) (
  input  wire logic sys_clk_in,                 // Processor clock
  input  wire logic sys_rst_in,                 // Async reset, high
  input  wire logic clk_en_in,                  // Freezes all state when low
  input  wire logic map_select_strap_in,        // Program map strap
  // Core request
  input  wire logic req_in,                     // Access request
  input  wire logic req_pm_in,                  // 1 program, 0 data space
  input  wire logic req_write_in,               // 1 write, 0 read
  input  wire logic req_data_in,                // Program data, not code
  input  wire logic [ext_mem_pkg::ADDR_W-1:0]  req_addr_in,   // Word addr
  input  wire logic [ext_mem_pkg::WORD_W-1:0]  req_wdata_in,  // Write word
  output logic      done_out,                   // Access finished, pulse
  output logic      busy_out,                   // External cycle running
  output logic      fault_out,                  // Reserved address, pulse
  output logic      [ext_mem_pkg::BUS_W-1:0]   rdata_out,     // Read word
  // Extension register
  input  wire logic px_load_in,                 // Core writes extension
  input  wire logic [ext_mem_pkg::PX_W-1:0]    px_wdata_in,   // New value
  output logic      [ext_mem_pkg::PX_W-1:0]    pm_low_byte_reg_out, // Value
  // Wait settings
  input  wire logic wait_load_in,               // Take wait settings
  input  wire logic [ext_mem_pkg::WAIT_W-1:0]  pm_wait_in,    // Program
  input  wire logic [ext_mem_pkg::NUM_ZONES*ext_mem_pkg::WAIT_W-1:0]
                    dm_wait_in,                 // Per-zone data waits
  // Boot handshake
  input  wire logic boot_done_in,               // Boot loader finished
  output logic      boot_req_out,               // Boot load wanted
  // External pins
  output logic      [ext_mem_pkg::ADDR_W-1:0]  ext_addr_out,  // Address
  input  wire logic [ext_mem_pkg::BUS_W-1:0]   ext_data_in,   // Data in
  output logic      [ext_mem_pkg::BUS_W-1:0]   ext_data_out,  // Data out
  output logic      ext_data_oe_out,            // High while driving
  output logic      prog_mem_select_n_out,      // Program select, low
  output logic      data_mem_select_n_out,      // Data select, low
  output logic      rd_n_out,                   // Read strobe, low
  output logic      wr_n_out                    // Write strobe, low
);
  localparam int AW = ext_mem_pkg::ADDR_W;
  localparam int BW = ext_mem_pkg::BUS_W;
  localparam int DW = ext_mem_pkg::WORD_W;
  localparam int PW = ext_mem_pkg::PX_W;
  localparam int WW = ext_mem_pkg::WAIT_W;
  localparam int LO = ext_mem_pkg::DM_LANE_LO;

  // ******************************************************
  // State
  // ******************************************************
  ext_mem_pkg::bus_state_e state_q, state_d;
  logic [AW-1:0] addr_q,   addr_d;
  logic [BW-1:0] dout_q,   dout_d;
  logic [BW-1:0] rdata_q,  rdata_d;
  logic [PW-1:0] px_q,     px_d;
  logic [WW-1:0] cnt_q,    cnt_d;
  logic          oe_q,     oe_d;
  logic          pms_n_q,  pms_n_d;
  logic          dms_n_q,  dms_n_d;
  logic          rd_n_q,   rd_n_d;
  logic          wr_n_q,   wr_n_d;
  logic          done_q,   done_d;
  logic          fault_q,  fault_d;
  logic          busy_q,   busy_d;
  logic          cur_pm_q, cur_pm_d;
  logic          cur_wr_q, cur_wr_d;
  logic          cur_dat_q, cur_dat_d;
  logic          map_hi_q;
  logic          strap_taken_q;
  logic          boot_req_q;

  // On-chip memories behind the shared decoder
  logic [BW-1:0] pm_ram [ext_mem_pkg::PM_WORDS];
  logic [DW-1:0] dm_ram [ext_mem_pkg::DM_WORDS];

  // ******************************************************
  // Address decode and wait selection
  // ******************************************************
  mem_map_if map ();

  assign map.addr   = req_addr_in;
  assign map.is_pm  = req_pm_in;
  assign map.map_hi = map_hi_q;

  mem_map_decoder #(
    .ZONE_BOUNDS (ZONE_BOUNDS)
  ) u_decoder (
    .map (map)
  );

  logic [WW-1:0] wait_count;

  wait_state_bank u_waits (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .load_in    (wait_load_in),
    .pm_wait_in (pm_wait_in),
    .dm_wait_in (dm_wait_in),
    .sel_pm_in  (req_pm_in),
    .zone_in    (map.zone),
    .count_out  (wait_count)
  );

  // ******************************************************
  // Request steering
  // ******************************************************
  // Requests are only looked at between bus cycles
  wire idle      = state_q == ext_mem_pkg::ST_IDLE;
  wire take      = idle && req_in;
  wire take_ext  = take && map.external;
  wire take_int  = take && map.internal;
  wire take_rsv  = take && map.reserved;
  wire last_wait = (state_q == ext_mem_pkg::ST_STROBE) && (cnt_q == '0);

  // Word sent out: program space appends the extension byte
  wire [BW-1:0] pm_wword = {req_wdata_in, px_q};          // RL7
  wire [BW-1:0] dm_wword = {req_wdata_in, {LO{1'b0}}};    // RL13
  wire [BW-1:0] wword    = req_pm_in ? pm_wword : dm_wword;

  // Internal RAM lookup; both maps put the block on a 1K boundary
  wire [ext_mem_pkg::PM_IDX_W-1:0] pm_idx =
    req_addr_in[ext_mem_pkg::PM_IDX_W-1:0];
  wire [ext_mem_pkg::DM_IDX_W-1:0] dm_idx =
    req_addr_in[ext_mem_pkg::DM_IDX_W-1:0];
  wire [BW-1:0] pm_ram_word = pm_ram[pm_idx];
  wire [DW-1:0] dm_ram_word = dm_ram[dm_idx];

  // Read results as the core sees them
  wire [BW-1:0] ext_word16 = {{PW{1'b0}}, ext_data_in[BW-1:LO]};
  wire [BW-1:0] ext_result =
    (cur_pm_q && !cur_dat_q) ? ext_data_in : ext_word16;
  wire [BW-1:0] int_result =
    !req_pm_in ? {{PW{1'b0}}, dm_ram_word} :
    req_data_in ? {{PW{1'b0}}, pm_ram_word[BW-1:LO]} : pm_ram_word;

  // Extension capture on program data reads, from pins or from RAM
  wire px_ext_cap = last_wait && cur_pm_q && cur_dat_q && !cur_wr_q;
  wire px_int_cap = take_int && req_pm_in && req_data_in &&
                    !req_write_in;

  // ******************************************************
  // Bus cycle sequencer
  // ******************************************************
  // Outputs are computed one cycle ahead so every pin leaves a flop
  always_comb begin
    state_d   = state_q;
    addr_d    = addr_q;
    dout_d    = dout_q;
    rdata_d   = rdata_q;
    cnt_d     = cnt_q;
    oe_d      = oe_q;
    pms_n_d   = pms_n_q;
    dms_n_d   = dms_n_q;
    rd_n_d    = rd_n_q;
    wr_n_d    = wr_n_q;
    busy_d    = busy_q;
    cur_pm_d  = cur_pm_q;
    cur_wr_d  = cur_wr_q;
    cur_dat_d = cur_dat_q;
    done_d    = 1'b0;
    fault_d   = 1'b0;
    case (state_q)
      ext_mem_pkg::ST_IDLE: begin
        if (take_ext) begin
          // Same cycle shape for code, data and peripherals
          state_d   = ext_mem_pkg::ST_STROBE;   // RL2 RL14
          addr_d    = req_addr_in;              // RL1 RL13
          pms_n_d   = !req_pm_in;               // RL4
          dms_n_d   = req_pm_in;                // RL5
          rd_n_d    = req_write_in;             // RL6
          wr_n_d    = !req_write_in;            // RL6
          oe_d      = req_write_in;             // RL3
          dout_d    = wword;                    // RL3
          cnt_d     = wait_count;               // RL12 RL17
          busy_d    = 1'b1;
          cur_pm_d  = req_pm_in;
          cur_wr_d  = req_write_in;
          cur_dat_d = req_data_in;
        end else if (take_int) begin
          // On-chip RAM answers next cycle, pins stay quiet
          done_d = 1'b1;                        // RL11
          if (!req_write_in) begin
            rdata_d = int_result;
          end
        end else if (take_rsv) begin
          // Reserved space reads zero and flags the access
          done_d  = 1'b1;                       // RL16
          fault_d = 1'b1;
          rdata_d = '0;
        end
      end
      ext_mem_pkg::ST_STROBE: begin
        if (cnt_q == '0) begin
          state_d = ext_mem_pkg::ST_IDLE;
          pms_n_d = 1'b1;
          dms_n_d = 1'b1;
          rd_n_d  = 1'b1;
          wr_n_d  = 1'b1;
          oe_d    = 1'b0;
          busy_d  = 1'b0;
          done_d  = 1'b1;
          if (!cur_wr_q) begin
            rdata_d = ext_result;               // RL3 RL13
          end
        end else begin
          // One more cycle of strobe per wait state
          cnt_d = cnt_q - WW'(1);               // RL19
        end
      end
      default: begin
        state_d = ext_mem_pkg::ST_IDLE;
        pms_n_d = 1'b1;
        dms_n_d = 1'b1;
        rd_n_d  = 1'b1;
        wr_n_d  = 1'b1;
        oe_d    = 1'b0;
        busy_d  = 1'b0;
      end
    endcase
  end

  // ******************************************************
  // Extension register next value
  // ******************************************************
  // Hardware capture beats a core load in the same cycle
  always_comb begin
    px_d = px_q;
    if (px_ext_cap) begin
      px_d = ext_data_in[PW-1:0];               // RL8
    end else if (px_int_cap) begin
      px_d = pm_ram_word[PW-1:0];               // RL8
    end else if (px_load_in) begin
      px_d = px_wdata_in;
    end
  end

  // ******************************************************
  // Registers
  // ******************************************************
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q   <= ext_mem_pkg::ST_IDLE;
      addr_q    <= '0;
      dout_q    <= '0;
      rdata_q   <= '0;
      px_q      <= ext_mem_pkg::PX_RESET;
      cnt_q     <= '0;
      oe_q      <= 1'b0;
      pms_n_q   <= 1'b1;
      dms_n_q   <= 1'b1;
      rd_n_q    <= 1'b1;
      wr_n_q    <= 1'b1;
      done_q    <= 1'b0;
      fault_q   <= 1'b0;
      busy_q    <= 1'b0;
      cur_pm_q  <= 1'b0;
      cur_wr_q  <= 1'b0;
      cur_dat_q <= 1'b0;
    end else if (clk_en_in) begin
      state_q   <= state_d;
      addr_q    <= addr_d;
      dout_q    <= dout_d;
      rdata_q   <= rdata_d;
      px_q      <= px_d;
      cnt_q     <= cnt_d;
      oe_q      <= oe_d;
      pms_n_q   <= pms_n_d;
      dms_n_q   <= dms_n_d;
      rd_n_q    <= rd_n_d;
      wr_n_q    <= wr_n_d;
      done_q    <= done_d;
      fault_q   <= fault_d;
      busy_q    <= busy_d;
      cur_pm_q  <= cur_pm_d;
      cur_wr_q  <= cur_wr_d;
      cur_dat_q <= cur_dat_d;
    end
  end

  // ******************************************************
  // Strap capture and boot request
  // ******************************************************
  // The strap is caught once after reset, so a late swing of the pin
  // cannot move the program map under running code
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      map_hi_q      <= 1'b0;
      strap_taken_q <= 1'b0;
      boot_req_q    <= 1'b0;
    end else if (clk_en_in) begin
      if (!strap_taken_q) begin
        strap_taken_q <= 1'b1;
        map_hi_q      <= map_select_strap_in;    // RL9 RL10
        boot_req_q    <= !map_select_strap_in;   // RL11
      end else if (boot_done_in) begin
        boot_req_q    <= 1'b0;
      end
    end
  end

  // ******************************************************
  // On-chip RAM writes
  // ******************************************************
  // No reset on the arrays: contents are undefined until written
  always_ff @(posedge sys_clk_in) begin
    if (clk_en_in && take_int && req_write_in) begin
      if (req_pm_in) begin
        pm_ram[pm_idx] <= pm_wword;              // RL7 RL11
      end else begin
        dm_ram[dm_idx] <= req_wdata_in;          // RL15
      end
    end
  end

  // ******************************************************
  // Outputs
  // ******************************************************
  assign done_out              = done_q;
  assign busy_out              = busy_q;
  assign fault_out             = fault_q;
  assign rdata_out             = rdata_q;
  assign pm_low_byte_reg_out   = px_q;
  assign boot_req_out          = boot_req_q;
  assign ext_addr_out          = addr_q;
  assign ext_data_out          = dout_q;
  assign ext_data_oe_out       = oe_q;
  assign prog_mem_select_n_out = pms_n_q;
  assign data_mem_select_n_out = dms_n_q;
  assign rd_n_out              = rd_n_q;
  assign wr_n_out              = wr_n_q;
endmodule // dsp_external_memory_interface
`default_nettype wire

// ---- src/ext_mem_pkg.sv ----
`default_nettype none
package ext_mem_pkg;
  // ******************************************************
  // Bus widths
  // ******************************************************
  localparam int ADDR_W    = 14;
  localparam int BUS_W     = 24;
  localparam int WORD_W    = 16;
  localparam int PX_W      = 8;
  localparam int WAIT_W    = 3;
  localparam int NUM_ZONES = 5;
  localparam int ZONE_W    = 3;
  localparam int PM_IDX_W  = 10;
  localparam int DM_IDX_W  = 9;
  localparam int PM_WORDS  = 1024;
  localparam int DM_WORDS  = 512;
  // Data memory word rides on the upper lanes of the bus
  localparam int DM_LANE_LO = 8;

  // ******************************************************
  // Reset values
  // ******************************************************
  localparam logic [WAIT_W-1:0] WAIT_RESET = 3'h7;
  localparam logic [PX_W-1:0]   PX_RESET   = 8'h00;

  // ******************************************************
  // Memory map
  // ******************************************************
  localparam logic [ADDR_W-1:0] PM_LO_RSV_BASE = 14'h0400;
  localparam logic [ADDR_W-1:0] PM_LO_EXT_BASE = 14'h0800;
  localparam logic [ADDR_W-1:0] PM_HI_INT_BASE = 14'h3800;
  localparam logic [ADDR_W-1:0] PM_HI_RSV_BASE = 14'h3C00;
  localparam logic [ADDR_W-1:0] DM_INT_BASE    = 14'h3800;
  localparam logic [ADDR_W-1:0] DM_RSV_BASE    = 14'h3A00;
  // Lower bounds of zones 1..4; zone 0 starts at address zero
  localparam logic [(NUM_ZONES-1)*ADDR_W-1:0] ZONE_BOUNDS =
    {14'h3000, 14'h2000, 14'h1000, 14'h0800};

  // ******************************************************
  // Bus cycle states
  // ******************************************************
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h1,
    ST_STROBE = 2'h2
  } bus_state_e;
endpackage
`default_nettype wire

// ---- src/mem_map_if.sv ----
`default_nettype none
interface mem_map_if;
  logic [ext_mem_pkg::ADDR_W-1:0] addr;
  logic                           is_pm;
  logic                           map_hi;
  logic                           internal;
  logic                           reserved;
  logic                           external;
  logic [ext_mem_pkg::ZONE_W-1:0] zone;

  modport decoder (
    input  addr, is_pm, map_hi,
    output internal, reserved, external, zone
  );
  modport user (
    output addr, is_pm, map_hi,
    input  internal, reserved, external, zone
  );
endinterface
`default_nettype wire

// ---- src/mem_map_decoder.sv ----
`default_nettype none
module mem_map_decoder #(
  parameter logic [(ext_mem_pkg::NUM_ZONES-1)*ext_mem_pkg::ADDR_W-1:0]
    ZONE_BOUNDS = ext_mem_pkg::ZONE_BOUNDS
) (
  mem_map_if.decoder map    // Address in, region and zone out
);
  localparam int NB = ext_mem_pkg::NUM_ZONES - 1;
  localparam int AW = ext_mem_pkg::ADDR_W;

  // ******************************************************
  // Program and data regions
  // ******************************************************
  wire pm_lo_int = map.addr <  ext_mem_pkg::PM_LO_RSV_BASE;
  wire pm_lo_rsv = !pm_lo_int &&
                   (map.addr < ext_mem_pkg::PM_LO_EXT_BASE);
  wire pm_hi_int = (map.addr >= ext_mem_pkg::PM_HI_INT_BASE) &&
                   (map.addr <  ext_mem_pkg::PM_HI_RSV_BASE);
  wire pm_hi_rsv = map.addr >= ext_mem_pkg::PM_HI_RSV_BASE;
  wire pm_int    = map.map_hi ? pm_hi_int : pm_lo_int;  // RL9 RL10
  wire pm_rsv    = map.map_hi ? pm_hi_rsv : pm_lo_rsv;  // RL9 RL10
  wire dm_int    = (map.addr >= ext_mem_pkg::DM_INT_BASE) &&
                   (map.addr <  ext_mem_pkg::DM_RSV_BASE);  // RL15
  // Control registers live here and never reach the pins
  wire dm_rsv    = map.addr >= ext_mem_pkg::DM_RSV_BASE;    // RL15 RL16

  assign map.internal = map.is_pm ? pm_int : dm_int;
  assign map.reserved = map.is_pm ? pm_rsv : dm_rsv;
  assign map.external = !map.internal && !map.reserved;

  // ******************************************************
  // Zone select: one compare per boundary
  // ******************************************************
  wire [NB-1:0] above;
  genvar k;
  generate
    for (k = 0; k < NB; k++) begin : g_bound
      assign above[k] = map.addr >= ZONE_BOUNDS[k*AW +: AW];  // RL17 RL20
    end
  endgenerate

  // Boundaries ascend, so the zone is the count of those passed
  always_comb begin
    logic [ext_mem_pkg::ZONE_W-1:0] n;
    n = '0;
    for (int i = 0; i < NB; i++) begin
      n = n + {{(ext_mem_pkg::ZONE_W-1){1'b0}}, above[i]};
    end
    map.zone = n;
  end
endmodule // mem_map_decoder
`default_nettype wire

// ---- src/wait_state_bank.sv ----
`default_nettype none
module wait_state_bank (
  input  wire logic                          sys_clk_in,  // Clock
  input  wire logic                          sys_rst_in,  // Async reset
  input  wire logic                          clk_en_in,   // Clock enable
  input  wire logic                          load_in,     // Take settings
  input  wire logic [ext_mem_pkg::WAIT_W-1:0] pm_wait_in, // Program waits
  input  wire logic [ext_mem_pkg::NUM_ZONES*ext_mem_pkg::WAIT_W-1:0]
                                             dm_wait_in,  // Zone waits
  input  wire logic                          sel_pm_in,   // Program space
  input  wire logic [ext_mem_pkg::ZONE_W-1:0] zone_in,    // Data zone
  output logic      [ext_mem_pkg::WAIT_W-1:0] count_out   // Selected count
);
  localparam int WW = ext_mem_pkg::WAIT_W;
  localparam int NZ = ext_mem_pkg::NUM_ZONES;

  logic [WW-1:0] pm_wait_q;
  logic [WW-1:0] dm_wait_q [NZ];

  // ******************************************************
  // Settings, slowest possible until software loads them
  // ******************************************************
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pm_wait_q <= ext_mem_pkg::WAIT_RESET;  // RL12
    end else if (clk_en_in && load_in) begin
      pm_wait_q <= pm_wait_in;  // RL12
    end
  end

  genvar z;
  generate
    for (z = 0; z < NZ; z++) begin : g_zone
      always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          dm_wait_q[z] <= ext_mem_pkg::WAIT_RESET;  // RL18
        end else if (clk_en_in && load_in) begin
          dm_wait_q[z] <= dm_wait_in[z*WW +: WW];  // RL17 RL20
        end
      end
    end
  endgenerate

  // Out-of-range zone falls back to the last zone
  wire [ext_mem_pkg::ZONE_W-1:0] zsel =
    (zone_in < ext_mem_pkg::ZONE_W'(NZ)) ? zone_in
                                         : ext_mem_pkg::ZONE_W'(NZ - 1);
  assign count_out = sel_pm_in ? pm_wait_q : dm_wait_q[zsel];
endmodule // wait_state_bank
`default_nettype wire

// ---- verification/ext_mem_model.sv ----
`default_nettype none
// External memory: one word per address, no wait of its own
module ext_mem_model (
  input  wire logic        clk_in,    // Clock
  input  wire logic [13:0] addr_in,   // Address
  input  wire logic [23:0] wdata_in,  // From device
  input  wire logic        sel_n_in,  // Any select
  input  wire logic        rd_n_in,   // Read strobe
  input  wire logic        wr_n_in,   // Write strobe
  output logic      [23:0] rdata_out  // To device
);
  timeunit 1ns / 1ps;
  logic [23:0] mem [0:16383];
  logic [23:0] last_q = 24'h00_0000;
  wire         rd_act = !sel_n_in && !rd_n_in;
  // Store every write strobe cycle, remember what was last driven
  always @(posedge clk_in) begin
    if (!sel_n_in && !wr_n_in) mem[addr_in] <= wdata_in;
    if (rd_act) last_q <= mem[addr_in];
  end
  // A released bus must not look like the last word
  assign rdata_out = rd_act ? mem[addr_in] : ~last_q;
endmodule // ext_mem_model
`default_nettype wire

// ---- verification/ext_mem_monitor.sv ----
`default_nettype none
module ext_mem_monitor (
  input wire logic        sys_clk_in,             // Clock
  input wire logic        sys_rst_in,             // Reset
  input wire logic        clk_en_in,              // Enable
  input wire logic        req_in,                 // Request
  input wire logic        req_pm_in,              // Space
  input wire logic [13:0] req_addr_in,            // Address
  input wire logic        done_out,               // Done
  input wire logic        busy_out,               // Busy
  input wire logic        fault_out,              // Fault
  input wire logic [7:0]  pm_low_byte_reg_out,    // Extension
  input wire logic [23:0] ext_data_out,           // Bus out
  input wire logic        ext_data_oe_out,        // Bus enable
  input wire logic        prog_mem_select_n_out,  // Program select
  input wire logic        data_mem_select_n_out,  // Data select
  input wire logic        rd_n_out,               // Read
  input wire logic        wr_n_out                // Write
);
  timeunit 1ns / 1ps;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Busy is low only in idle, so a request is taken then
  wire take = req_in && !busy_out && clk_en_in;
  wire psel = !prog_mem_select_n_out;
  wire dsel = !data_mem_select_n_out;
  AST_SEL_ONE: assert property (!(psel && dsel)) else $error("two");
  AST_STB_SEL: assert property ((!rd_n_out || !wr_n_out) |->
    busy_out && (rd_n_out != wr_n_out)) else $error("bad strobe");
  AST_BUSY_SEL: assert property (busy_out == (psel || dsel))
    else $error("select not tied to busy");
  AST_OE_WR: assert property (ext_data_oe_out == !wr_n_out)
    else $error("bus enable off write");
  AST_DM_LANE: assert property (dsel && !wr_n_out |->
    ext_data_out[7:0] == 8'h00) else $error("low lanes used");
  AST_PM_PX: assert property (psel && !wr_n_out |->
    ext_data_out[7:0] == pm_low_byte_reg_out) else $error("low byte");
  AST_DONE_END: assert property ($fell(busy_out) |-> done_out)
    else $error("no done after strobe");
  AST_FLT_DONE: assert property (fault_out |-> done_out)
    else $error("fault without done");
  AST_DM_INT: assert property (take && !req_pm_in && req_addr_in >=
    14'h3800 |=> done_out && !dsel && fault_out == ($past(req_addr_in)
    >= 14'h3A00)) else $error("internal data access");
  AST_DM_EXT: assert property (take && !req_pm_in && req_addr_in <
    14'h3800 |=> busy_out && dsel ##[1:8] done_out)
    else $error("external data access");
  cover property (take && req_pm_in ##1 !wr_n_out);
  cover property (fault_out);
  cover property ($rose(data_mem_select_n_out));
endmodule // ext_mem_monitor
bind dsp_external_memory_interface ext_mem_monitor ext_mem_monitor_i (.*);
`default_nettype wire

// ---- verification/tb_dsp_external_memory_interface.sv ----
`default_nettype none
module tb_dsp_external_memory_interface;
  timeunit 1ns / 1ps;
  logic clk = 0, rst = 1, strap = 0, req = 0, rpm = 0, rwr = 0, rdt = 0;
  logic pxl = 0, wl = 0, bdone = 0, done, busy, flt, breq, xoe, ps, ds, rn, wn;
  logic [13:0] raddr = 14'h0000, xa;
  logic [15:0] rwd = 16'h0000;
  logic [7:0]  pxw = 8'h00, px;
  logic [2:0]  pmw = 3'h0;
  logic [14:0] dmw = 15'h0000;
  logic [23:0] rdata, xdo, xdi, cyc, got, f;
  int n_errors = 0, checks = 0, ticks = 0;
  always #4 clk = ~clk;
  dsp_external_memory_interface dsp_external_memory_interface_i (
    .sys_clk_in(clk), .sys_rst_in(rst), .clk_en_in(1'b1),
    .map_select_strap_in(strap), .req_in(req), .req_pm_in(rpm),
    .req_write_in(rwr), .req_data_in(rdt), .req_addr_in(raddr),
    .req_wdata_in(rwd), .done_out(done), .busy_out(busy), .fault_out(flt),
    .rdata_out(rdata), .px_load_in(pxl), .px_wdata_in(pxw),
    .pm_low_byte_reg_out(px), .wait_load_in(wl), .pm_wait_in(pmw),
    .dm_wait_in(dmw), .boot_done_in(bdone), .boot_req_out(breq),
    .ext_addr_out(xa), .ext_data_in(xdi), .ext_data_out(xdo),
    .ext_data_oe_out(xoe), .prog_mem_select_n_out(ps),
    .data_mem_select_n_out(ds), .rd_n_out(rn), .wr_n_out(wn));
  ext_mem_model ext_mem_model_i (.clk_in(clk), .addr_in(xa),
    .wdata_in(xdo), .sel_n_in(ps & ds), .rd_n_in(rn), .wr_n_in(wn),
    .rdata_out(xdi));
  // ****************************************************
  // Tasks
  // ****************************************************
  task chk(input logic [23:0] g, e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task reset(input logic s);
    rst = 1;
    strap = s;
    repeat (16) @(negedge clk);
    rst = 0;
    repeat (2) @(negedge clk);
  endtask
  // One access; cyc counts edges from the take edge to done
  task acc(input logic pm, wr, dt, input logic [13:0] a,
           input logic [15:0] wd);
    @(negedge clk);
    {req, rpm, rwr, rdt, raddr, rwd} = {1'b1, pm, wr, dt, a, wd};
    @(negedge clk);
    req = 0;
    cyc = 1;
    while (done !== 1'b1 && cyc < 20) begin
      @(negedge clk);
      cyc++;
    end
    got = (done === 1'b1) ? rdata : 'x;
    f = {23'h00_0000, flt};
  endtask
  task setcfg(input logic l, p, input logic [7:0] v, input logic [14:0] d);
    {pxl, wl, pxw, dmw} = {l, p, v, d};
    @(negedge clk);
    {pxl, wl} = 2'h0;
  endtask
  // Hang guard, far above the 160 or so cycles needed
  always @(posedge clk) begin
    ticks++;
    if (ticks == 3000) begin
      n_errors++;
      end_sim();
    end
  end
  // ****************************************************
  // Tests
  // ****************************************************
  initial begin
    reset(0);
    chk(px, 8'h00);
    chk(breq, 1);
    bdone = 1;
    @(negedge clk);
    bdone = 0;
    chk(breq, 0);
    acc(0, 1, 0, 14'h0900, 16'hBEEF); chk(cyc, 9);
    acc(0, 0, 0, 14'h0900, 0); chk(got, 24'h00_BEEF);
    acc(1, 1, 1, 14'h0A00, 16'h1111); chk(cyc, 9);
    $display("test default waits done");
    setcfg(0, 1, 0, {3'h4, 3'h3, 3'h2, 3'h1, 3'h0});
    for (int z = 0; z < 5; z++) begin
      acc(0, 1, 0, 14'(z * 'h800 + (z > 2 ? 'h800 * (z - 2) : 0)), 16'(z));
      chk(cyc, 24'(z + 2));
      acc(0, 0, 0, raddr, 0); chk(got, 24'(z));
    end
    $display("test zones done");
    setcfg(1, 0, 8'hA5, {3'h4, 3'h3, 3'h2, 3'h1, 3'h0});
    acc(1, 1, 1, 14'h0A00, 16'h1234); chk(cyc, 2);
    acc(1, 0, 0, 14'h0A00, 0); chk(got, 24'h12_34A5);
    setcfg(1, 0, 8'h00, {3'h4, 3'h3, 3'h2, 3'h1, 3'h0});
    acc(1, 0, 1, 14'h0A00, 0); chk(got, 24'h00_1234);
    chk(px, 8'hA5);
    acc(1, 1, 1, 14'h0010, 16'h5678); chk(cyc, 1);
    acc(1, 0, 0, 14'h0010, 0); chk(got, 24'h56_78A5);
    acc(1, 0, 0, 14'h0400, 0); chk(got | f, 24'h1);
    acc(0, 1, 0, 14'h3800, 16'h9ABC); chk(cyc, 1);
    acc(0, 0, 0, 14'h3800, 0); chk(got, 24'h00_9ABC);
    acc(0, 0, 0, 14'h3A00, 0); chk(f, 1);
    $display("test low map done");
    reset(1);
    chk(breq, 0);
    acc(1, 1, 1, 14'h0000, 16'hCAFE); chk(cyc, 9);
    acc(1, 1, 1, 14'h3800, 16'h0042); chk(cyc, 1);
    acc(1, 0, 1, 14'h3800, 0); chk(got, 24'h00_0042);
    acc(1, 0, 0, 14'h3C00, 0); chk(f, 1);
    $display("test high map done");
    end_sim();
  end
endmodule // tb_dsp_external_memory_interface
`default_nettype wire
